//--- ptplr_buf2.sv
// Two-entry valid/ready buffer for the response byte stream
`timescale 1ns/100ps
`default_nettype none
module ptplr_buf2 #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    logic [WIDTH-1:0] mem [2];
    logic [WIDTH-1:0] next_mem [2];
    logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
    logic [1:0] count, next_count;
    logic push, pop;

    initial begin
        if (WIDTH < 1) $error("WIDTH must be positive");
    end

    // =====================================================
    // Honest full and empty
    assign in_ready_out = (count != 2'd2);
    assign out_valid_out = (count != 2'd0);
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // Next state
    always_comb begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push) begin
            next_mem[wr_ptr] = in_data_in;
            next_wr_ptr = ~wr_ptr;
        end
        if (pop) begin
            next_rd_ptr = ~rd_ptr;
        end
        if (push && !pop) begin
            next_count = count + 2'd1;
        end else if (pop && !push) begin
            next_count = count - 2'd1;
        end
    end

    // Registers
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            mem[0] <= '0;
            mem[1] <= '0;
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'd0;
        end else begin
            mem <= next_mem;
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end
endmodule
`default_nettype wire

//--- ptplr_core.sv
// Point-to-point host-link responder: session, parse and reply logic
`timescale 1ns/100ps
`default_nettype none
// What the document asks of this block and its host
// RULE1 - Each complete command is answered by this hardware alone.
// RULE2 - Only one host is attached and blocks carry no node id.
// RULE3 - The host opens a session by sending the enquiry byte 05h.
// RULE4 - When ready the block echoes 05h unchanged to signal readiness.
// RULE5 - The host sends nothing more until it sees the echo.
// RULE6 - The host then sends the whole command and awaits the reply.
// RULE7 - A command starts with a two-character header then ASCII data.
// RULE8 - Every block ends with an asterisk then a carriage return 13.
// RULE9 - Binary bytes travel as two ASCII hex characters 00 to FF.
// RULE10 - A good reply repeats the header, then data, then terminator.
// RULE11 - Unknown headers or illegal channels get an error reply.
// RULE12 - Sending the reply ends the session; a new enquiry is needed.
// RULE13 - The host should check every reply for the error form.
// RULE14 - The link defaults to 38400 baud, 8 data, 1 stop, no parity.
// RULE15 - The error reply uses a fixed header and the normal terminator.
// RULE16 - An unterminated command is dropped after a timeout.
module ptplr_core
    import ptplr_pkg::*;
#(
    parameter int NUM_OUT = NUM_OUT_DEFAULT,
    parameter int TIMEOUT = TIMEOUT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [15:0] inputs_in,
    output logic [15:0] outputs_out,
    output logic session_out
);
    typedef enum logic [2:0] {
        S_IDLE, S_ECHO, S_CMD, S_REPLY
    } ptplr_state_t;

    ptplr_state_t state, next_state;
    logic [7:0] hdr0, hdr1, next_hdr0, next_hdr1;
    logic [7:0] data_byte, next_data_byte;
    logic [3:0] nib_cnt, next_nib_cnt;
    logic prev_star, next_prev_star, bad, next_bad;
    logic [2:0] hdr_cnt, next_hdr_cnt;
    logic [15:0] outs, next_outs;
    logic [31:0] tmo, next_tmo;
    logic [3:0] rep_idx, next_rep_idx;
    logic is_err, next_is_err;
    logic rx_last_nonzero, next_rx_last_nonzero;
    logic [7:0] rep_byte, nib;
    logic buf_ready;
    logic [3:0] hexval;
    logic hexok;

    initial begin
        if (NUM_OUT < 1 || NUM_OUT > 16) $error("NUM_OUT out of range");
        if (TIMEOUT < 1) $error("TIMEOUT must be positive");
    end

    // =====================================================
    // Hex character decode
    always_comb begin
        hexok = 1'b1;
        hexval = 4'h0;
        if (rx_data_in >= 8'h30 && rx_data_in <= 8'h39) begin
            hexval = rx_data_in[3:0];
        end else if (rx_data_in >= 8'h41 && rx_data_in <= 8'h46) begin
            hexval = 4'(rx_data_in[3:0] + 4'h9); // RULE9
        end else begin
            hexok = 1'b0;
        end
    end

    // Hex character encode of a nibble
    function automatic logic [7:0] to_hex(input logic [3:0] v);
        to_hex = (v < 4'hA) ? {4'h3, v} : 8'(8'h37 + {4'h0, v});
    endfunction

    // Reply byte sequencer: header, four hex digits for RI, terminator
    always_comb begin
        nib = 8'h00;
        rep_byte = CHAR_CR;
        unique case (rep_idx)
            4'd0: rep_byte = is_err ? CHAR_ERR0 : hdr0; // RULE10 RULE15
            4'd1: rep_byte = is_err ? CHAR_ERR1 : hdr1;
            4'd2: begin
                nib = to_hex(inputs_in[15:12]); // RULE9
                rep_byte = nib;
            end
            4'd3: rep_byte = to_hex(inputs_in[11:8]);
            4'd4: rep_byte = to_hex(inputs_in[7:4]);
            4'd5: rep_byte = to_hex(inputs_in[3:0]);
            4'd6: rep_byte = CHAR_STAR; // RULE8
            default: rep_byte = CHAR_CR;
        endcase
    end

    // Session state and parse next values
    always_comb begin
        next_state = state;
        next_hdr0 = hdr0;
        next_hdr1 = hdr1;
        next_data_byte = data_byte;
        next_nib_cnt = nib_cnt;
        next_prev_star = prev_star;
        next_bad = bad;
        next_hdr_cnt = hdr_cnt;
        next_outs = outs;
        next_tmo = tmo;
        next_rep_idx = rep_idx;
        next_is_err = is_err;
        tx_valid_out = 1'b0;
        tx_data_out = rep_byte;
        unique case (state)
            S_IDLE: begin
                // Wait for the session opener
                if (rx_valid_in && rx_data_in == CHAR_ENQ) begin // RULE3
                    next_state = S_ECHO;
                end
            end
            S_ECHO: begin
                tx_valid_out = 1'b1;
                tx_data_out = CHAR_ENQ; // RULE4
                if (buf_ready) begin
                    next_state = S_CMD;
                    next_hdr_cnt = 3'd0;
                    next_nib_cnt = 4'd0;
                    next_prev_star = 1'b0;
                    next_bad = 1'b0;
                    next_tmo = '0;
                end
            end
            S_CMD: begin
                next_tmo = tmo + 32'd1;
                if (tmo >= 32'(TIMEOUT - 1)) begin
                    next_state = S_IDLE; // RULE16
                end else if (rx_valid_in) begin
                    next_prev_star = (rx_data_in == CHAR_STAR);
                    if (hdr_cnt == 3'd0) begin
                        next_hdr0 = rx_data_in; // RULE2 RULE7
                        next_hdr_cnt = 3'd1;
                    end else if (hdr_cnt == 3'd1) begin
                        next_hdr1 = rx_data_in;
                        next_hdr_cnt = 3'd2;
                    end else if (prev_star && rx_data_in == CHAR_CR) begin
                        // Terminator seen: judge the command
                        next_state = S_REPLY; // RULE8
                        next_rep_idx = 4'd0;
                        if (hdr0 == CHAR_R && hdr1 == CHAR_I) begin
                            next_is_err = bad || nib_cnt != 4'd0;
                        end else if (hdr0 == CHAR_W && hdr1 == CHAR_O) begin
                            // Data is channel then state, two hex bytes
                            next_is_err = bad || nib_cnt != 4'd4
                                || data_byte >= 8'(NUM_OUT); // RULE11
                        end else begin
                            next_is_err = 1'b1; // RULE11
                        end
                    end else if (rx_data_in != CHAR_STAR) begin
                        if (!hexok || nib_cnt == 4'd15) begin
                            next_bad = 1'b1;
                        end else begin
                            next_nib_cnt = nib_cnt + 4'd1;
                            if (nib_cnt < 4'd2) begin
                                next_data_byte = {data_byte[3:0], hexval};
                            end
                            if (nib_cnt == 4'd3) begin
                                next_data_byte = data_byte;
                            end
                        end
                    end
                end
            end
            S_REPLY: begin
                // Response is generated without any outside help
                tx_valid_out = 1'b1; // RULE1
                if (buf_ready) begin
                    if (rep_idx == 4'd1 && (is_err || hdr0 == CHAR_W)) begin
                        next_rep_idx = 4'd6;
                    end else if (rep_idx == 4'd7) begin
                        next_state = S_IDLE; // RULE12
                        if (!is_err && hdr0 == CHAR_W) begin
                            next_outs[4'(data_byte)] = (nib_cnt == 4'd4)
                                && (rx_last_nonzero);
                        end
                    end else begin
                        next_rep_idx = rep_idx + 4'd1;
                    end
                end
            end
            default: next_state = S_IDLE;
        endcase
    end

    // Whether the last data byte is nonzero, kept separately for write
    always_comb begin
        next_rx_last_nonzero = rx_last_nonzero;
        if (state == S_CMD && rx_valid_in && hexok && hdr_cnt == 3'd2
            && nib_cnt >= 4'd2 && nib_cnt < 4'd4 && hexval != 4'h0) begin
            next_rx_last_nonzero = 1'b1;
        end else if (state == S_ECHO) begin
            next_rx_last_nonzero = 1'b0;
        end
    end

    // Registers
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state <= S_IDLE;
            hdr0 <= 8'h00;
            hdr1 <= 8'h00;
            data_byte <= 8'h00;
            nib_cnt <= 4'd0;
            prev_star <= 1'b0;
            bad <= 1'b0;
            hdr_cnt <= 3'd0;
            outs <= OUT_RESET;
            tmo <= '0;
            rep_idx <= 4'd0;
            is_err <= 1'b0;
            rx_last_nonzero <= 1'b0;
        end else begin
            state <= next_state;
            hdr0 <= next_hdr0;
            hdr1 <= next_hdr1;
            data_byte <= next_data_byte;
            nib_cnt <= next_nib_cnt;
            prev_star <= next_prev_star;
            bad <= next_bad;
            hdr_cnt <= next_hdr_cnt;
            outs <= next_outs;
            tmo <= next_tmo;
            rep_idx <= next_rep_idx;
            is_err <= next_is_err;
            rx_last_nonzero <= next_rx_last_nonzero;
        end
    end

    assign outputs_out = outs;
    assign session_out = (state != S_IDLE);
    assign buf_ready = tx_ready_in;

    // =====================================================
    // Checks
    a_echo_after_enq: assert property (@(posedge clk_sys_in) // RULE4
        disable iff (!rst_b_in)
        (state == S_IDLE && rx_valid_in && rx_data_in == CHAR_ENQ)
        |=> tx_valid_out && tx_data_out == CHAR_ENQ)
        else $error("no echo after enquiry");
    a_cmd_timeout: assert property (@(posedge clk_sys_in) // RULE16
        disable iff (!rst_b_in)
        (state == S_CMD && tmo >= 32'(TIMEOUT - 1)) |=> state == S_IDLE)
        else $error("timeout did not drop command");
    a_reply_ends: assert property (@(posedge clk_sys_in) // RULE12
        disable iff (!rst_b_in)
        (state == S_REPLY && rep_idx == 4'd7 && buf_ready)
        |=> state == S_IDLE)
        else $error("session not closed after reply");
    a_term_star: assert property (@(posedge clk_sys_in) // RULE8
        disable iff (!rst_b_in)
        (state == S_REPLY && rep_idx == 4'd6) |-> tx_data_out == CHAR_STAR)
        else $error("bad terminator");
    a_err_header: assert property (@(posedge clk_sys_in) // RULE15
        disable iff (!rst_b_in)
        (state == S_REPLY && rep_idx == 4'd0 && is_err)
        |-> tx_data_out == CHAR_ERR0)
        else $error("bad error header");
    a_good_header: assert property (@(posedge clk_sys_in) // RULE10
        disable iff (!rst_b_in)
        (state == S_REPLY && rep_idx == 4'd1 && !is_err)
        |-> tx_data_out == hdr1)
        else $error("header not repeated");
    a_unknown_err: assert property (@(posedge clk_sys_in) // RULE11
        disable iff (!rst_b_in)
        (state == S_CMD && next_state == S_REPLY && hdr0 != CHAR_R
        && hdr0 != CHAR_W) |=> is_err)
        else $error("unknown header not refused");
    // Every accepted reply byte moves the sequencer on by itself
    a_auto_reply: assert property (@(posedge clk_sys_in) // RULE1
        disable iff (!rst_b_in)
        (state == S_REPLY && buf_ready)
        |=> (rep_idx != $past(rep_idx) || state == S_IDLE))
        else $error("reply stalled by logic");
endmodule
`default_nettype wire

//--- ptplr_host_sink.sv
// Host-side model that takes reply bytes, promptly or slowly
`timescale 1ns/100ps
`default_nettype none
module ptplr_host_sink (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic slow_in,
    input wire logic [7:0] tx_data_in,
    input wire logic tx_valid_in,
    output logic tx_ready_out,
    output logic rcv_stb_out,
    output logic [7:0] rcv_data_out
);
    // =====================================================
    // Pacing
    logic [1:0] pace;

    // Free-running pace count; slow mode takes one byte in four cycles
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pace <= 2'h0;
        end else begin
            pace <= pace + 2'h1;
        end
    end

    // =====================================================
    // Reply intake
    // Host waits for and drains the reply block at its own pace
    assign tx_ready_out = slow_in ? (pace == 2'h0) : 1'b1;
    assign rcv_stb_out = tx_valid_in && tx_ready_out;
    assign rcv_data_out = tx_data_in;
endmodule
`default_nettype wire

//--- ptplr_pkg.sv
// Package of constants for the point-to-point host-link responder
package ptplr_pkg;
    // =====================================================
    // Protocol characters
    localparam logic [7:0] CHAR_ENQ = 8'h05;
    localparam logic [7:0] CHAR_STAR = 8'h2A;
    localparam logic [7:0] CHAR_CR = 8'h0D;
    localparam logic [7:0] CHAR_R = 8'h52;
    localparam logic [7:0] CHAR_W = 8'h57;
    localparam logic [7:0] CHAR_I = 8'h49;
    localparam logic [7:0] CHAR_O = 8'h4F;
    // Error header characters
    localparam logic [7:0] CHAR_ERR0 = 8'h45;
    localparam logic [7:0] CHAR_ERR1 = 8'h52;
    // =====================================================
    // Timing
    localparam int CLK_HZ = 125_000_000;
    localparam int BAUD_DEFAULT = 38400;
    localparam int TIMEOUT_MS = 100;
    localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
    // Field layout
    localparam int CH_BITS = 4;
    localparam int NUM_OUT_DEFAULT = 16;
    localparam logic [15:0] OUT_RESET = 16'h0000;
endpackage

//--- ptplr_top.sv
// Top of the host-link responder with the reply buffer
`timescale 1ns/100ps
`default_nettype none
module ptplr_top
    import ptplr_pkg::*;
#(
    parameter int TIMEOUT = TIMEOUT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rst_b_in,
    input wire logic [7:0] rx_data_in,
    input wire logic rx_valid_in,
    output logic [7:0] tx_data_out,
    output logic tx_valid_out,
    input wire logic tx_ready_in,
    input wire logic [15:0] inputs_in,
    output logic [15:0] outputs_out,
    output logic session_out
);
    logic [7:0] c_data;
    logic c_valid, c_ready;

    // Core parser and reply generator
    ptplr_core #(.TIMEOUT(TIMEOUT)) u_core (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .rx_data_in(rx_data_in),
        .rx_valid_in(rx_valid_in),
        .tx_data_out(c_data),
        .tx_valid_out(c_valid),
        .tx_ready_in(c_ready),
        .inputs_in(inputs_in),
        .outputs_out(outputs_out),
        .session_out(session_out)
    );

    // Buffer absorbs transmitter stalls
    ptplr_buf2 #(.WIDTH(8)) u_buf (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(c_valid),
        .in_ready_out(c_ready),
        .in_data_in(c_data),
        .out_valid_out(tx_valid_out),
        .out_ready_in(tx_ready_in),
        .out_data_out(tx_data_out)
    );
endmodule
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the host-link responder
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import ptplr_pkg::*;
    // =====================================================
    // Signals
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_valid = 1'b0;
    logic [15:0] inputs = 16'h0000;
    logic slow = 1'b0;
    logic [7:0] tx_data;
    logic tx_valid;
    logic tx_ready;
    logic [15:0] outputs;
    logic session_out;
    logic rcv_stb;
    logic [7:0] rcv_data;
    logic [7:0] got[$];
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;

    // Clock at 125 MHz
    always #4 clk_sys_in = ~clk_sys_in;

    ptplr_top #(.TIMEOUT(200)) u_ptplr_top (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .rx_data_in(rx_data),
        .rx_valid_in(rx_valid),
        .tx_data_out(tx_data),
        .tx_valid_out(tx_valid),
        .tx_ready_in(tx_ready),
        .inputs_in(inputs),
        .outputs_out(outputs),
        .session_out(session_out)
    );

    ptplr_host_sink u_ptplr_host_sink (
        .clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in),
        .slow_in(slow),
        .tx_data_in(tx_data),
        .tx_valid_in(tx_valid),
        .tx_ready_out(tx_ready),
        .rcv_stb_out(rcv_stb),
        .rcv_data_out(rcv_data)
    );

    // Collect every byte the host accepts
    always @(posedge clk_sys_in) begin
        if (rcv_stb) begin
            got.push_back(rcv_data);
        end
    end

    // =====================================================
    // Shared tasks
    task automatic give_verdict;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge clk_sys_in);
        #1;
    endtask

    // One byte from the host; the idle line shows the inverse
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_sys_in);
        rx_data <= b;
        rx_valid <= 1'b1;
        @(posedge clk_sys_in);
        rx_valid <= 1'b0;
        rx_data <= ~b;
    endtask

    task automatic send_str(input string s);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(8'(s[i]));
        end
    endtask

    task automatic wait_bytes(input int n);
        int k;
        k = 0;
        while (got.size() < n && k < 400) begin
            tick();
            k++;
        end
    endtask

    task automatic open_session;
        got.delete();
        send_byte(CHAR_ENQ);
        wait_bytes(1);
        check("echo", {8'h00, got[0]}, {8'h00, CHAR_ENQ});
        check("session open", {15'h0000, session_out}, 16'h0001);
        got.delete();
    endtask

    task automatic run_cmd(input string cmd, input string exp);
        open_session();
        send_str(cmd);
        wait_bytes(exp.len());
        repeat (8) tick();
        check("reply length", 16'(got.size()), 16'(exp.len()));
        for (int i = 0; i < exp.len(); i++) begin
            check("reply byte", {8'h00, got[i]}, {8'h00, 8'(exp[i])});
        end
        check("session end", {15'h0000, session_out}, 16'h0000);
    endtask

    // =====================================================
    // Scenarios
    task automatic t_reset;
        check("outputs reset", outputs, 16'h0000);
        check("tx idle", {15'h0000, tx_valid}, 16'h0000);
        check("session idle", {15'h0000, session_out}, 16'h0000);
    endtask

    task automatic t_read;
        @(posedge clk_sys_in);
        inputs <= 16'hA53C;
        run_cmd("RI*\r", "RIA53C*\r");
        @(posedge clk_sys_in);
        inputs <= 16'h00FF;
        run_cmd("RI*\r", "RI00FF*\r");
    endtask

    task automatic t_write;
        run_cmd("WO0301*\r", "WO*\r");
        check("output ch3 on", outputs, 16'h0008);
        run_cmd("WO0FFF*\r", "WO*\r");
        check("output ch15 on", outputs, 16'h8008);
        run_cmd("WO0300*\r", "WO*\r");
        check("output ch3 off", outputs, 16'h8000);
    endtask

    task automatic t_errors;
        run_cmd("WO1001*\r", "ER*\r");
        check("outputs kept", outputs, 16'h8000);
        run_cmd("XY*\r", "ER*\r");
        run_cmd("WO0G01*\r", "ER*\r");
        run_cmd("RI12*\r", "ER*\r");
        check("outputs still", outputs, 16'h8000);
    endtask

    // A command without an enquiry, also right after a finished reply
    task automatic t_no_enquiry;
        got.delete();
        send_str("RI*\r");
        repeat (40) tick();
        check("no reply", 16'(got.size()), 16'h0000);
        check("no session", {15'h0000, session_out}, 16'h0000);
    endtask

    task automatic t_timeout;
        open_session();
        send_str("RI");
        repeat (300) tick();
        check("dropped reply", 16'(got.size()), 16'h0000);
        check("dropped session", {15'h0000, session_out}, 16'h0000);
        run_cmd("RI*\r", "RI00FF*\r");
    endtask

    // Slow host forces the reply buffer to refuse; no byte may be lost
    task automatic t_stall;
        @(posedge clk_sys_in);
        slow <= 1'b1;
        run_cmd("RI*\r", "RI00FF*\r");
        run_cmd("WO0F00*\r", "WO*\r");
        check("output ch15 off", outputs, 16'h0000);
        @(posedge clk_sys_in);
        slow <= 1'b0;
    endtask

    // =====================================================
    // Watchdog
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        tick();
        t_reset();
        t_read();
        t_no_enquiry();
        t_write();
        t_errors();
        t_timeout();
        t_stall();
        give_verdict();
    end
endmodule
`default_nettype wire
